//--- hdl/wrps_top.sv
// wake timer, wake source, reset cause and supply status block
`timescale 1ns/100ps
`default_nettype none
`include "wrps_cfg.svh"
module wrps_top #(
  parameter int unsigned SECOND_CYC = `WRPS_SECOND_CYC
) (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  // configuration ram access
  input  wire logic [`WRPS_ADDR_W-1:0] addr_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  input  wire logic [7:0]              wdata_i,
  output logic      [7:0]              rdata_o,
  // supply comparators, from analog pins
  input  wire logic                    analog_supply_good_i,
  input  wire logic                    main_supply_good_i,
  input  wire logic                    core_supply_good_i,
  input  wire logic                    core_supply_above_two_i,
  input  wire logic                    core_trim_fuse_bit_i,
  output logic      [2:0]              supply_status_code_o,
  output logic                         flash_write_block_o,
  output logic                         pll_fast_clear_o,
  // power mode requests from the processor
  input  wire logic                    sleep_request_i,
  input  wire logic                    display_only_request_i,
  output logic                         wake_o,
  output logic                         watchdog_restart_o,
  // wake sources, already debounced or one-cycle events on this clock
  input  wire logic [2:0]              pin_wake_enable_i,
  input  wire logic [2:0]              pin_wake_event_i,
  input  wire logic                    temp_wake_i,
  input  wire logic                    pushbutton_input_i,
  input  wire logic                    serial_rx_wake_i,
  // reset causes, latched at reset release
  input  wire logic [5:0]              reset_cause_i
);
  logic a_ok;
  logic m_ok;
  logic c_ok;
  logic c_two;

  wrps_sync u_sync_a (.clock_i(clock_i), .rst_n_i(rst_n_i),
                      .async_i(analog_supply_good_i), .sync_o(a_ok));
  wrps_sync u_sync_m (.clock_i(clock_i), .rst_n_i(rst_n_i),
                      .async_i(main_supply_good_i), .sync_o(m_ok));
  wrps_sync u_sync_c (.clock_i(clock_i), .rst_n_i(rst_n_i),
                      .async_i(core_supply_good_i), .sync_o(c_ok));
  wrps_sync u_sync_t (.clock_i(clock_i), .rst_n_i(rst_n_i),
                      .async_i(core_supply_above_two_i), .sync_o(c_two));

  // supply status
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic       fblk_q;
  logic       fblk_d;
  logic       pclr_q;
  logic       pclr_d;

  always_comb begin
    if (a_ok && m_ok) begin
      stat_d = `WRPS_ST_OK;
    end else if (m_ok) begin
      stat_d = `WRPS_ST_LOW;
    end else if (c_ok && c_two) begin
      stat_d = `WRPS_ST_BAT_OK;
    end else if (c_two) begin
      stat_d = `WRPS_ST_BAT_MARGIN;
    end else begin
      stat_d = `WRPS_ST_BAT_FAIL;
    end
    fblk_d = (stat_d == `WRPS_ST_BAT_MARGIN);
    pclr_d = fblk_d && core_trim_fuse_bit_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_q <= `WRPS_ST_BAT_FAIL;
      fblk_q <= 1'b0;
      pclr_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      fblk_q <= fblk_d;
      pclr_q <= pclr_d;
    end
  end

  // register writes
  logic [7:0] reload_q;
  logic [7:0] reload_d;
  logic       arm_q;
  logic       arm_d;
  logic       wdr_q;
  logic       wdr_d;
  logic       arm_set;
  logic       wr_reload;
  logic       wr_arm;
  logic       wr_wdog;

  assign wr_reload = wr_i && (addr_i == `WRPS_OFS_WAKE_RELOAD);
  assign wr_arm    = wr_i && (addr_i == `WRPS_OFS_WAKE_ARM);
  assign wr_wdog   = wr_i && (addr_i == `WRPS_OFS_WDOG);

  // timer
  wrps_pkg::wrps_tmr_e tst_q;
  wrps_pkg::wrps_tmr_e tst_d;
  logic [8:0]          secs_q;
  logic [8:0]          secs_d;
  logic                wake_q;
  logic                wake_d;
  logic                tick;
  logic                low_power;

  assign low_power = sleep_request_i || display_only_request_i;
  assign arm_set   = wr_arm && wdata_i[`WRPS_BIT_ARM];

  always_comb begin
    reload_d = wr_reload ? wdata_i : reload_q;
    arm_d    = wr_arm ? wdata_i[`WRPS_BIT_ARM] : arm_q;
    // write-only strobe, never stored
    wdr_d    = wr_wdog && wdata_i[`WRPS_BIT_WDOG_RESTART];
    tst_d    = tst_q;
    secs_d   = secs_q;
    wake_d   = 1'b0;
    if (arm_set) begin
      tst_d  = wrps_pkg::WRPS_TMR_ARMED;
      secs_d = {1'b0, reload_d} + 9'h001;
    end else if (!arm_q) begin
      tst_d = wrps_pkg::WRPS_TMR_IDLE;
    end else begin
      unique case (tst_q)
        wrps_pkg::WRPS_TMR_IDLE: begin
          tst_d = wrps_pkg::WRPS_TMR_IDLE;
        end
        wrps_pkg::WRPS_TMR_ARMED: begin
          if (low_power) begin
            tst_d = wrps_pkg::WRPS_TMR_RUN;
          end
        end
        wrps_pkg::WRPS_TMR_RUN: begin
          if (!low_power) begin
            tst_d = wrps_pkg::WRPS_TMR_ARMED;
          end else if (tick) begin
            secs_d = secs_q - 9'h001;
            if (secs_q == 9'h001) begin
              tst_d  = wrps_pkg::WRPS_TMR_DONE;
              wake_d = 1'b1;
            end
          end
        end
        wrps_pkg::WRPS_TMR_DONE: begin
          tst_d = wrps_pkg::WRPS_TMR_DONE;
        end
      endcase
    end
  end

  // tick restarts while not counting, so seconds start at run entry
  wrps_tick #(.PERIOD(SECOND_CYC)) u_tick (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .clear_i(tst_q != wrps_pkg::WRPS_TMR_RUN),
    .tick_o (tick)
  );

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_q <= `WRPS_RELOAD_RST;
      arm_q    <= 1'b0;
      wdr_q    <= 1'b0;
      tst_q    <= wrps_pkg::WRPS_TMR_IDLE;
      secs_q   <= 9'h000;
      wake_q   <= 1'b0;
    end else begin
      reload_q <= reload_d;
      arm_q    <= arm_d;
      wdr_q    <= wdr_d;
      tst_q    <= tst_d;
      secs_q   <= secs_d;
      wake_q   <= wake_d;
    end
  end

  // wake source flags; set wins except on pin flags, which clear while their enable is low; others cleared only by reset
  logic [2:0] pinf_q;
  logic [2:0] pinf_d;
  logic       tempf_q;
  logic       tempf_d;
  logic       btnf_q;
  logic       btnf_d;
  logic       rxf_q;
  logic       rxf_d;
  logic [5:0] cause_q;
  logic [5:0] cause_d;
  logic       cap_q;
  logic       cap_d;

  always_comb begin
    pinf_d  = (pinf_q | pin_wake_event_i) & pin_wake_enable_i;
    tempf_d = tempf_q | temp_wake_i;
    btnf_d  = btnf_q | pushbutton_input_i;
    rxf_d   = rxf_q | serial_rx_wake_i;
    // cause captured on the first clock after reset release
    cap_d   = 1'b1;
    cause_d = cap_q ? cause_q : reset_cause_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pinf_q  <= 3'h0;
      tempf_q <= 1'b0;
      btnf_q  <= 1'b0;
      rxf_q   <= 1'b0;
      cause_q <= `WRPS_CAUSE_RST;
      cap_q   <= 1'b0;
    end else begin
      pinf_q  <= pinf_d;
      tempf_q <= tempf_d;
      btnf_q  <= btnf_d;
      rxf_q   <= rxf_d;
      cause_q <= cause_d;
      cap_q   <= cap_d;
    end
  end

  // read port, unmapped and write-only reads give zero
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        `WRPS_OFS_WAKE_RELOAD: rdata_d = reload_q;
        `WRPS_OFS_RESET_CAUSE: rdata_d = {cause_q, 2'b00};
        `WRPS_OFS_WAKE_FLAGS: begin
          rdata_d[`WRPS_BIT_TEMP]   = tempf_q;
          rdata_d[`WRPS_BIT_SERIAL] = rxf_q;
          rdata_d[`WRPS_BIT_BUTTON] = btnf_q;
          rdata_d[`WRPS_BIT_PIN_A]  = pinf_q[2];
          rdata_d[`WRPS_BIT_PIN_B]  = pinf_q[1];
          rdata_d[`WRPS_BIT_PIN_C]  = pinf_q[0];
        end
        `WRPS_OFS_WAKE_ARM: rdata_d[`WRPS_BIT_ARM] = arm_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o              = rdata_q;
  assign supply_status_code_o = stat_q;
  assign flash_write_block_o  = fblk_q;
  assign pll_fast_clear_o     = pclr_q;
  assign wake_o               = wake_q;
  assign watchdog_restart_o   = wdr_q;
endmodule
`default_nettype wire

//--- hdl/wrps_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef WRPS_CFG_SVH
`define WRPS_CFG_SVH
`define WRPS_ADDR_W            16
`define WRPS_OFS_WAKE_RELOAD   16'h2880
`define WRPS_OFS_RESET_CAUSE   16'h28b0
`define WRPS_OFS_WAKE_FLAGS    16'h28b1
`define WRPS_OFS_WAKE_ARM      16'h28b2
`define WRPS_OFS_WDOG          16'h28b4
`define WRPS_BIT_ARM           5
`define WRPS_BIT_WDOG_RESTART  7
`define WRPS_BIT_TEMP          6
`define WRPS_BIT_SERIAL        4
`define WRPS_BIT_BUTTON        3
`define WRPS_BIT_PIN_A         2
`define WRPS_BIT_PIN_B         1
`define WRPS_BIT_PIN_C         0
`define WRPS_CAUSE_LSB         2
`define WRPS_RELOAD_RST        8'h00
`define WRPS_CAUSE_RST         6'h10
`define WRPS_CLK_HZ            25000000
`define WRPS_SECOND_S          1
`define WRPS_SECOND_CYC        (`WRPS_CLK_HZ * `WRPS_SECOND_S)
`define WRPS_ST_OK             3'h0
`define WRPS_ST_LOW            3'h1
`define WRPS_ST_BAT_OK         3'h2
`define WRPS_ST_BAT_MARGIN     3'h3
`define WRPS_ST_BAT_FAIL       3'h5
`endif

//--- hdl/wrps_pkg.sv
// types shared by the wake, reset and power status block
package wrps_pkg;
  typedef enum logic [1:0] {
    WRPS_TMR_IDLE,
    WRPS_TMR_ARMED,
    WRPS_TMR_RUN,
    WRPS_TMR_DONE
  } wrps_tmr_e;
endpackage

//--- hdl/wrps_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module wrps_sync (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // level
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

//--- hdl/wrps_tick.sv
// divider that gives a one-cycle pulse once per period
`timescale 1ns/100ps
`default_nettype none
module wrps_tick #(
  parameter int unsigned PERIOD = 25000000
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic clear_i,
  output logic      tick_o
);
  localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_q;
  logic          tick_d;

  // restarts on clear so the first second is a whole one
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (clear_i) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule
`default_nettype wire

//--- tb/wrps_top_chk.sv
// port assertions for the wake, reset and power status block
`timescale 1ns/100ps
`default_nettype none
`include "wrps_cfg.svh"
module wrps_top_chk #(
  parameter int unsigned SECOND_CYC = 10
) (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  // config ram access
  input wire logic [15:0] addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  wdata_i,
  input wire logic [7:0]  rdata_o,
  // supplies and outputs
  input wire logic        analog_supply_good_i,
  input wire logic        main_supply_good_i,
  input wire logic        core_supply_good_i,
  input wire logic        core_supply_above_two_i,
  input wire logic [2:0]  supply_status_code_o,
  input wire logic        flash_write_block_o,
  input wire logic        pll_fast_clear_o,
  input wire logic        wake_o,
  input wire logic        watchdog_restart_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic wd_wr;
  logic all_low;
  assign wd_wr = wr_i && addr_i == `WRPS_OFS_WDOG && wdata_i[`WRPS_BIT_WDOG_RESTART];
  assign all_low = !analog_supply_good_i && !main_supply_good_i &&
                   !core_supply_good_i && !core_supply_above_two_i;
  chk_wdog_pulse:
    assert property (wd_wr |=> watchdog_restart_o) else $error("restart write gave no pulse");
  chk_wdog_cause:
    assert property (watchdog_restart_o |-> $past(wd_wr)) else $error("restart pulse without write");
  chk_wo_reads_zero:
    assert property (rd_i && addr_i == `WRPS_OFS_WDOG |=> rdata_o == 8'h00)
    else $error("write-only byte read nonzero");
  chk_rdata_idle:
    assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data without read");
  chk_status_ok:
    assert property ((analog_supply_good_i && main_supply_good_i)[*5]
      |-> supply_status_code_o == `WRPS_ST_OK) else $error("status not 000");
  chk_status_low:
    assert property ((!analog_supply_good_i && main_supply_good_i)[*5]
      |-> supply_status_code_o == `WRPS_ST_LOW) else $error("status not 001");
  chk_status_bat:
    assert property ((!analog_supply_good_i && !main_supply_good_i && core_supply_good_i &&
      core_supply_above_two_i)[*5] |-> supply_status_code_o == `WRPS_ST_BAT_OK)
    else $error("status not 010");
  chk_status_margin:
    assert property ((!analog_supply_good_i && !main_supply_good_i && !core_supply_good_i &&
      core_supply_above_two_i)[*5] |-> supply_status_code_o == `WRPS_ST_BAT_MARGIN)
    else $error("status not 011");
  chk_status_fail:
    assert property (all_low[*5] |-> supply_status_code_o == `WRPS_ST_BAT_FAIL)
    else $error("status not 101");
  chk_flash_block:
    assert property (flash_write_block_o == (supply_status_code_o == `WRPS_ST_BAT_MARGIN))
    else $error("flash block out of step with status");
  chk_pll_margin:
    assert property (pll_fast_clear_o |-> flash_write_block_o) else $error("pll clear outside 011");
  chk_wake_single:
    assert property (wake_o |=> !wake_o) else $error("wake pulse too long");
  cov_wake: cover property (wake_o);
  cov_wdog: cover property (watchdog_restart_o);
  cov_block: cover property (flash_write_block_o);
  cov_pll: cover property (pll_fast_clear_o);
endmodule
bind wrps_top wrps_top_chk #(.SECOND_CYC(SECOND_CYC)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .analog_supply_good_i(analog_supply_good_i),
  .main_supply_good_i(main_supply_good_i), .core_supply_good_i(core_supply_good_i),
  .core_supply_above_two_i(core_supply_above_two_i),
  .supply_status_code_o(supply_status_code_o), .flash_write_block_o(flash_write_block_o),
  .pll_fast_clear_o(pll_fast_clear_o), .wake_o(wake_o), .watchdog_restart_o(watchdog_restart_o)
);
`default_nettype wire

//--- tb/wrps_cpu.sv
// processor model issuing config ram byte accesses
`timescale 1ns/100ps
`default_nettype none
module wrps_cpu (
  // clock
  input  wire logic        clock_i,
  // config ram access
  output logic      [15:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [7:0]  wdata_o,
  input  wire logic [7:0]  rdata_i
);
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clock_i);
    wr_o = 1'b0;
    // stale data must not look valid
    wdata_o = ~d;
  endtask
  task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clock_i);
    d = rdata_i;
    rd_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/wrps_top_test.sv
// self-checking testbench for the wake, reset and power status block
`timescale 1ns/100ps
`default_nettype none
`include "wrps_cfg.svh"
module wrps_top_test;
  localparam int unsigned SEC = 10;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic        wr, rd, va, vm, vc, vt, fuse, slp, dsp, tmp, pb, rx;
  logic        fblk, pllc, wake, wdr;
  logic [2:0]  code, pen, pev;
  logic [5:0]  cause;
  int          error_cnt = 0;
  int          samples_checked = 0;
  always #20 clock_i = ~clock_i;
  wrps_cpu cpu (.clock_i(clock_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
    .rdata_i(rdata));
  wrps_top #(.SECOND_CYC(SEC)) DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .rdata_o(rdata), .analog_supply_good_i(va), .main_supply_good_i(vm),
    .core_supply_good_i(vc), .core_supply_above_two_i(vt), .core_trim_fuse_bit_i(fuse),
    .supply_status_code_o(code), .flash_write_block_o(fblk), .pll_fast_clear_o(pllc),
    .sleep_request_i(slp), .display_only_request_i(dsp), .wake_o(wake),
    .watchdog_restart_o(wdr), .pin_wake_enable_i(pen), .pin_wake_event_i(pev),
    .temp_wake_i(tmp), .pushbutton_input_i(pb), .serial_rx_wake_i(rx), .reset_cause_i(cause));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_win(input int n, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, n, lo, hi);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd_byte(a, d);
    cmp8(d, e);
  endtask
  task automatic pulse2(output logic p);
    p = wdr;
    @(negedge clock_i);
    p = p | wdr;
  endtask
  task automatic wait_wake(output int n);
    n = 0;
    while (wake !== 1'b1 && n < 300) begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task automatic t_regs;
    rchk(`WRPS_OFS_WAKE_RELOAD, 8'h00);
    rchk(`WRPS_OFS_RESET_CAUSE, 8'ha8);
    rchk(`WRPS_OFS_WAKE_FLAGS, 8'h00);
    rchk(`WRPS_OFS_WAKE_ARM, 8'h00);
    rchk(16'h2881, 8'h00);
    cpu.wr_byte(`WRPS_OFS_RESET_CAUSE, 8'hff);
    rchk(`WRPS_OFS_RESET_CAUSE, 8'ha8);
    cpu.wr_byte(`WRPS_OFS_WAKE_RELOAD, 8'ha5);
    rchk(`WRPS_OFS_WAKE_RELOAD, 8'ha5);
    $display("regs test done");
  endtask
  task automatic t_status;
    logic [3:0] vin [5] = '{4'hc, 4'h4, 4'h3, 4'h1, 4'h0};
    logic [2:0] exp [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    for (int i = 0; i < 5; i++) begin
      {va, vm, vc, vt} = vin[i];
      fuse = 1'b1;
      repeat (5) @(negedge clock_i);
      cmp8({5'h00, code}, {5'h00, exp[i]});
      cmp8({6'h00, fblk, pllc}, {6'h00, {2{i == 3}}});
    end
    {va, vm, vc, vt} = 4'h1;
    fuse = 1'b0;
    repeat (5) @(negedge clock_i);
    cmp8({6'h00, fblk, pllc}, 8'h02);
    {va, vm, vc, vt} = 4'hc;
    repeat (5) @(negedge clock_i);
    $display("status test done");
  endtask
  task automatic t_wdog;
    logic p;
    cpu.wr_byte(`WRPS_OFS_WDOG, 8'h80);
    pulse2(p);
    cmp8({7'h00, p}, 8'h01);
    cpu.wr_byte(`WRPS_OFS_WDOG, 8'h7f);
    pulse2(p);
    cmp8({7'h00, p}, 8'h00);
    rchk(`WRPS_OFS_WDOG, 8'h00);
    $display("watchdog test done");
  endtask
  task automatic t_timer;
    int n;
    cpu.wr_byte(`WRPS_OFS_WAKE_RELOAD, 8'h02);
    cpu.wr_byte(`WRPS_OFS_WAKE_ARM, 8'h20);
    rchk(`WRPS_OFS_WAKE_ARM, 8'h20);
    n = 0;
    repeat (40) begin
      @(negedge clock_i);
      // an unknown wake counts as a fault too
      n += int'(wake !== 1'b0);
    end
    cmp_win(n, 0, 0);
    slp = 1'b1;
    wait_wake(n);
    cmp_win(n, 3 * SEC, 3 * SEC + 4);
    slp = 1'b0;
    cpu.wr_byte(`WRPS_OFS_WAKE_ARM, 8'h00);
    cpu.wr_byte(`WRPS_OFS_WAKE_RELOAD, 8'h00);
    cpu.wr_byte(`WRPS_OFS_WAKE_ARM, 8'h20);
    dsp = 1'b1;
    wait_wake(n);
    cmp_win(n, SEC, SEC + 4);
    dsp = 1'b0;
    $display("timer test done");
  endtask
  task automatic t_flags;
    pen = 3'b101;
    {pev, tmp, pb, rx} = 6'h3f;
    @(negedge clock_i);
    {pev, tmp, pb, rx} = 6'h00;
    rchk(`WRPS_OFS_WAKE_FLAGS, 8'h5d);
    pen = 3'b001;
    @(negedge clock_i);
    rchk(`WRPS_OFS_WAKE_FLAGS, 8'h59);
    $display("flags test done");
  endtask
  task automatic t_reset;
    cause = 6'h05;
    rst_n_i = 1'b0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    rchk(`WRPS_OFS_RESET_CAUSE, 8'h14);
    rchk(`WRPS_OFS_WAKE_FLAGS, 8'h00);
    rchk(`WRPS_OFS_WAKE_RELOAD, 8'h00);
    rchk(`WRPS_OFS_WAKE_ARM, 8'h00);
    $display("reset test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {va, vm, vc, vt, fuse, slp, dsp, tmp, pb, rx} = 10'h300;
    pen = 3'h0;
    pev = 3'h0;
    cause = 6'h2a;
    repeat (8) @(negedge clock_i);
    rst_n_i = 1'b1;
    t_regs;
    t_status;
    t_wdog;
    t_timer;
    t_flags;
    t_reset;
    print_verdict;
  end
  // whole run is well under a thousand cycles
  initial begin
    #100us;
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
